// ### logic/pvs_pkg.sv
`default_nettype none
package pvs_pkg;
  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register indices
  localparam logic [4:0] REG_VCS      = 5'h11;
  localparam logic [4:0] REG_TBS      = 5'h12;
  localparam logic [4:0] REG_IRQ_STAT = 5'h1A;
  localparam logic [4:0] REG_IRQ_CLR  = 5'h1B;
  localparam logic [4:0] REG_IRQ_EN   = 5'h1C;

  // Vendor configuration and status fields
  localparam int VCS_MODE_LSB = 12;
  localparam int VCS_RSV_LSB  = 9;
  localparam int VCS_ADDR_LSB = 4;
  localparam int VCS_DBG_LSB  = 0;

  // Ten-megabit configuration and status fields
  localparam int TBS_LP_BIT  = 14;
  localparam int TBS_HB_BIT  = 13;
  localparam int TBS_SQ_BIT  = 12;
  localparam int TBS_JAB_BIT = 11;
  localparam int TBS_SER_BIT = 10;
  localparam int TBS_POL_BIT = 0;

  // Interrupt status bits
  localparam int IRQ_W       = 3;
  localparam int IRQ_AN_DONE = 0;
  localparam int IRQ_POL     = 1;
  localparam int IRQ_DBG     = 2;

  // Reset values
  localparam logic [3:0] MODE_RST = 4'hF;
  localparam logic [3:0] DBG_RST  = 4'h0;
  localparam logic       LP_RST   = 1'h1;
  localparam logic       HB_RST   = 1'h1;
  localparam logic       SQ_RST   = 1'h1;
  localparam logic       JAB_RST  = 1'h1;
  localparam logic       POL_RST  = 1'h0;
  localparam logic [2:0] IRQ_RST  = 3'h0;

  // Cycles the raw polarity must disagree before the flag follows
  localparam int POL_FILT_CYCLES = 8;

  // Negotiation debug codes
  typedef enum logic [3:0] {
    AN_IDLE      = 4'h0,
    AN_ABIL_OK   = 4'h1,
    AN_ACK_OK    = 4'h2,
    AN_ACK_FAIL  = 4'h3,
    AN_CONS_OK   = 4'h4,
    AN_CONS_FAIL = 4'h5,
    AN_PD_READY  = 4'h6,
    AN_PD_FAIL   = 4'h7,
    AN_DONE_OK   = 4'h8
  } pvs_an_code_t;
endpackage
`default_nettype wire

// ### logic/pvs_an_mon.sv
`default_nettype none
module pvs_an_mon
  import pvs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Negotiation engine
  input  wire logic       an_done,
  input  wire logic [3:0] an_result,
  input  wire logic [3:0] an_state_code,
  // Captured status
  output logic      [3:0] mode_flags,
  output logic      [3:0] dbg_code,
  output logic            done_evt,
  output logic            dbg_evt
);
  logic legal;  // Code lies in the documented set

  assign legal = (an_state_code <= AN_DONE_OK);

  // Resolved mode only moves when negotiation finishes
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_flags <= MODE_RST;
    end else if (an_done) begin
      mode_flags <= an_result;
    end
  end

  // Illegal codes are dropped so software never sees a bogus state
  always_ff @(posedge clk) begin
    if (rst) begin
      dbg_code <= DBG_RST;
    end else if (legal) begin
      dbg_code <= an_state_code;
    end
  end

  // Events line up with the register update
  always_ff @(posedge clk) begin
    done_evt <= !rst && an_done;
    dbg_evt  <= !rst && legal && (an_state_code != dbg_code);
  end

  AST_DBG_HOLD: assert property (@(posedge clk) disable iff (rst)
    !legal |=> $stable(dbg_code)) else $error("debug code took illegal value");
endmodule
`default_nettype wire

// ### logic/pvs_pol_filt.sv
`default_nettype none
module pvs_pol_filt
  import pvs_pkg::*;
#(
  parameter int FILT = POL_FILT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw detector level from the receiver
  input  wire logic raw,
  // Filtered flag and its change pulse
  output logic      flag,
  output logic      flip_evt
);
  localparam int CW = $clog2(FILT + 1);

  logic [CW-1:0] cnt;  // Cycles of disagreement so far
  logic          hit;  // Disagreement lasted long enough

  assign hit = (raw != flag) && (cnt == CW'(FILT - 1));

  // Flag is set and cleared by the receiver alone; glitches are filtered
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= POL_RST;
      cnt  <= '0;
    end else if (raw == flag) begin
      cnt <= '0;
    end else if (hit) begin
      flag <= raw;
      cnt  <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // One pulse per change of the flag
  always_ff @(posedge clk) begin
    flip_evt <= !rst && hit;
  end

  AST_POL_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $changed(flag) |-> $past(raw) == flag) else $error("polarity flag moved without cause");
endmodule
`default_nettype wire

// ### logic/pvs_regs.sv
`default_nettype none
module pvs_regs
  import pvs_pkg::*;
#(
  parameter int POL_FILT = POL_FILT_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Straps caught at reset
  input  wire logic [4:0]        strap_addr,
  input  wire logic              strap_serial,
  // Negotiation engine
  input  wire logic              an_mode,
  input  wire logic              an_done,
  input  wire logic [3:0]        an_result,
  input  wire logic [3:0]        an_state_code,
  // Operating conditions
  input  wire logic              speed_100,
  input  wire logic              full_duplex,
  input  wire logic              loopback_10,
  input  wire logic              rx_pol_raw,
  // Controls to the datapath
  output logic      [4:0]        mgmt_device_address,
  output logic                   mode_flags_valid,
  output logic                   link_pulse_tx,
  output logic                   force_good_link,
  output logic                   heartbeat_on,
  output logic                   jabber_on,
  output logic                   squelch_normal,
  output logic                   serial_host_mode,
  // Interrupt
  output logic                   irq
);
  // Status captured from the negotiation engine
  logic [3:0] mode_flags;             // Resolved mode, one-hot
  logic [3:0] negotiation_debug_code; // Negotiation state code
  logic       done_evt;               // Negotiation finished
  logic       dbg_evt;                // Debug code changed

  // Polarity status
  logic polarity_reversed_flag;  // Filtered polarity
  logic pol_evt;                 // Polarity flag moved

  // Writable configuration
  logic link_pulse_enable;        // Link pulses on
  logic heartbeat_enable;         // Heartbeat on
  logic squelch_enable;           // Normal squelch
  logic jabber_enable;            // Jabber on
  logic serial_host_mode_select;  // Serial host mode

  // Interrupt registers
  logic [IRQ_W-1:0] irq_stat;    // Sticky events
  logic [IRQ_W-1:0] irq_en;      // Enable mask
  logic [IRQ_W-1:0] irq_clr;     // Clear mask of this cycle
  logic [IRQ_W-1:0] irq_events;  // Events of this cycle

  // Decoded accesses
  logic             wr_vcs;   // Write to vendor register
  logic             wr_tbs;   // Write to ten-megabit register
  logic [DATA_W-1:0] rd_word; // Word for the current address

  assign wr_vcs = wr && (addr == REG_VCS);
  assign wr_tbs = wr && (addr == REG_TBS);

  // Negotiation status capture
  pvs_an_mon u_an_mon (
    .clk           (clk),
    .rst           (rst),
    .an_done       (an_done),
    .an_result     (an_result),
    .an_state_code (an_state_code),
    .mode_flags    (mode_flags),
    .dbg_code      (negotiation_debug_code),
    .done_evt      (done_evt),
    .dbg_evt       (dbg_evt)
  );

  // Polarity filter on the receive side
  pvs_pol_filt #(
    .FILT (POL_FILT)
  ) u_pol_filt (
    .clk      (clk),
    .rst      (rst),
    .raw      (rx_pol_raw),
    .flag     (polarity_reversed_flag),
    .flip_evt (pol_evt)
  );

  // Address field: strap value at reset, software may change it later
  always_ff @(posedge clk) begin
    if (rst) begin
      mgmt_device_address <= strap_addr;
    end else if (wr_vcs) begin
      // Only the address field is taken; status bits ignore the write
      mgmt_device_address <= wdata[VCS_ADDR_LSB +: 5];
    end
  end

  // Ten-megabit options; reserved and read-only bits are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      link_pulse_enable <= LP_RST;
      heartbeat_enable  <= HB_RST;
      squelch_enable    <= SQ_RST;
      jabber_enable     <= JAB_RST;
    end else if (wr_tbs) begin
      link_pulse_enable <= wdata[TBS_LP_BIT];
      heartbeat_enable  <= wdata[TBS_HB_BIT];
      squelch_enable    <= wdata[TBS_SQ_BIT];
      jabber_enable     <= wdata[TBS_JAB_BIT];
    end
  end

  // Serial mode select has its own strap reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_host_mode_select <= strap_serial;
    end else if (wr_tbs) begin
      serial_host_mode_select <= wdata[TBS_SER_BIT];
    end
  end

  // Datapath controls, registered so they never glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_flags_valid <= 1'b0;
      link_pulse_tx    <= 1'b0;
      force_good_link  <= 1'b0;
      heartbeat_on     <= 1'b0;
      jabber_on        <= 1'b0;
      squelch_normal   <= SQ_RST;
      serial_host_mode <= 1'b0;
    end else begin
      // Flags only describe a negotiated link
      mode_flags_valid <= an_mode;
      // The link pulse bit has no effect at 100 Mbps
      link_pulse_tx    <= link_pulse_enable && !speed_100;
      force_good_link  <= !link_pulse_enable && !speed_100;
      // No collision, so no heartbeat, in full duplex
      heartbeat_on     <= heartbeat_enable && !full_duplex;
      // The bit governs only the two named ten-megabit modes
      if (!speed_100 && (full_duplex || loopback_10)) begin
        jabber_on <= jabber_enable;
      end else begin
        jabber_on <= 1'b1;
      end
      squelch_normal   <= squelch_enable;
      // Serial host mode cannot run at 100 Mbps
      serial_host_mode <= serial_host_mode_select && !speed_100;
    end
  end

  // Read word assembly; reserved positions stay zero
  always_comb begin
    rd_word = '0;
    unique case (addr)
      REG_VCS: begin
        rd_word[VCS_MODE_LSB +: 4] = mode_flags;
        rd_word[VCS_ADDR_LSB +: 5] = mgmt_device_address;
        rd_word[VCS_DBG_LSB +: 4]  = negotiation_debug_code;
      end
      REG_TBS: begin
        rd_word[TBS_LP_BIT]  = link_pulse_enable;
        rd_word[TBS_HB_BIT]  = heartbeat_enable;
        rd_word[TBS_SQ_BIT]  = squelch_enable;
        rd_word[TBS_JAB_BIT] = jabber_enable;
        rd_word[TBS_SER_BIT] = serial_host_mode_select;
        rd_word[TBS_POL_BIT] = polarity_reversed_flag;
      end
      REG_IRQ_STAT: begin
        rd_word[IRQ_W-1:0] = irq_stat;
      end
      REG_IRQ_EN: begin
        rd_word[IRQ_W-1:0] = irq_en;
      end
      // Clear register and unmapped addresses read zero
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= rd_word;
    end else begin
      rdata <= '0;
    end
  end

  // Interrupt sources and the clear of this cycle
  assign irq_events = {dbg_evt, pol_evt, done_evt};
  assign irq_clr    = (wr && addr == REG_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0;

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat <= IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_events;
    end
  end

  // Enable mask
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en <= IRQ_RST;
    end else if (wr && addr == REG_IRQ_EN) begin
      irq_en <= wdata[IRQ_W-1:0];
    end
  end

  // Level interrupt, combinational from the two registers
  assign irq = |(irq_stat & irq_en);

  // Checks on the register behaviour
  AST_MODE_RST: assert property (@(posedge clk)
    rst |=> mode_flags == MODE_RST) else $error("mode flags not all ones after reset");

  AST_MODE_LOAD: assert property (@(posedge clk) disable iff (rst)
    an_done |=> mode_flags == $past(an_result)) else $error("resolved mode not latched");

  AST_MODE_VALID: assert property (@(posedge clk) disable iff (rst)
    ##1 mode_flags_valid == $past(an_mode)) else $error("valid flag does not follow mode");

  AST_RSV_VCS: assert property (@(posedge clk) disable iff (rst)
    rd && addr == REG_VCS |=> rdata[VCS_RSV_LSB +: 3] == 3'h0) else $error("reserved bits read nonzero");

  AST_RSV_TBS: assert property (@(posedge clk) disable iff (rst)
    rd && addr == REG_TBS |=> rdata[15] == 1'b0 && rdata[9:1] == 9'h000)
    else $error("reserved bits read nonzero");

  AST_ADDR_WR: assert property (@(posedge clk) disable iff (rst)
    wr_vcs ##1 rd && addr == REG_VCS |=> rdata[VCS_ADDR_LSB +: 5] == $past(wdata[VCS_ADDR_LSB +: 5], 2))
    else $error("address field not written");

  AST_DBG_READ: assert property (@(posedge clk) disable iff (rst)
    rd && addr == REG_VCS |=> rdata[VCS_DBG_LSB +: 4] == $past(negotiation_debug_code))
    else $error("debug code not read back");

  AST_LINK: assert property (@(posedge clk) disable iff (rst)
    !speed_100 && !link_pulse_enable |=> force_good_link && !link_pulse_tx)
    else $error("good link not forced");

  AST_HB_FDX: assert property (@(posedge clk) disable iff (rst)
    full_duplex |=> !heartbeat_on) else $error("heartbeat active in full duplex");

  AST_JAB: assert property (@(posedge clk) disable iff (rst)
    !speed_100 && full_duplex |=> jabber_on == $past(jabber_enable)) else $error("jabber ignores its bit");

  AST_SER_100: assert property (@(posedge clk) disable iff (rst)
    speed_100 |=> !serial_host_mode) else $error("serial mode at 100 Mbps");

  AST_POL_READ: assert property (@(posedge clk) disable iff (rst)
    rd && addr == REG_TBS |=> rdata[TBS_POL_BIT] == $past(polarity_reversed_flag))
    else $error("polarity flag not read back");

  AST_RO_KEEP: assert property (@(posedge clk) disable iff (rst)
    wr_vcs && !an_done |=> $stable(mode_flags)) else $error("write changed resolved mode");

  AST_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
    done_evt && irq_en[IRQ_AN_DONE] |=> irq) else $error("interrupt not raised");

  // Main scenarios
  COV_AN_DONE: cover property (@(posedge clk) disable iff (rst) an_done ##1 rd && addr == REG_VCS);
  COV_POL: cover property (@(posedge clk) disable iff (rst) pol_evt);
  COV_CLR_RACE: cover property (@(posedge clk) disable iff (rst) irq_clr[IRQ_DBG] && dbg_evt);
  COV_SER: cover property (@(posedge clk) disable iff (rst) serial_host_mode);
  // Back-to-back write and read of the address field, no idle cycle between
  COV_ADDR_B2B: cover property (@(posedge clk) disable iff (rst) wr_vcs ##1 rd && addr == REG_VCS);
endmodule
`default_nettype wire

// ### tb/pvs_mgmt_model.sv
`default_nettype none
module pvs_mgmt_model
  import pvs_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register port towards the transceiver
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Address last given to the transceiver; one entry, one device on the link
  logic [4:0] known_addr;

  // Idle bus at time zero
  initial begin
    addr       = '0;
    wdata      = '0;
    wr         = 1'b0;
    rd         = 1'b0;
    known_addr = '0;
  end

  // One-cycle write; released lines show the inverse so stale values never match
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    if (a == REG_VCS) begin
      known_addr = d[8:4];
    end
  endtask

  // Write followed at once by a read, no idle cycle between the strobes
  task automatic wr_rd_reg(input logic [4:0] a, input logic [15:0] w, output logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= w;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    if (a == REG_VCS) begin
      known_addr = w[8:4];
    end
    @(posedge clk);
    rd    <= 1'b0;
    addr  <= ~a;
    wdata <= ~w;
    #1 d = rdata;
  endtask

  // One-cycle read; data only valid in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb
  import pvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and register port
  logic              clk, rst, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  // Straps and operating conditions
  logic [4:0]        strap_addr;
  logic              strap_serial, an_mode, an_done, speed_100, full_duplex, loopback_10, rx_pol_raw;
  logic [3:0]        an_result, an_state_code;
  // Outputs towards the datapath
  logic [4:0]        mgmt_device_address;
  logic              mode_flags_valid, link_pulse_tx, force_good_link, heartbeat_on, jabber_on;
  logic              squelch_normal, serial_host_mode, irq;
  // Score
  int                mismatches, n_tests;

  // Management controller on the far side
  pvs_mgmt_model mgr (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // Short filter keeps the polarity test brief
  pvs_regs #(.POL_FILT(2)) DUT (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .strap_addr(strap_addr), .strap_serial(strap_serial), .an_mode(an_mode), .an_done(an_done),
    .an_result(an_result), .an_state_code(an_state_code), .speed_100(speed_100),
    .full_duplex(full_duplex), .loopback_10(loopback_10), .rx_pol_raw(rx_pol_raw),
    .mgmt_device_address(mgmt_device_address), .mode_flags_valid(mode_flags_valid),
    .link_pulse_tx(link_pulse_tx), .force_good_link(force_good_link), .heartbeat_on(heartbeat_on),
    .jabber_on(jabber_on), .squelch_normal(squelch_normal), .serial_host_mode(serial_host_mode),
    .irq(irq));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Register word compare
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Port level compare
  task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected controls from config word, speed, duplex and loopback
  function automatic logic [5:0] exp_ctl(logic [15:0] w, logic s, logic f, logic l);
    logic jb;
    jb = (!s && (f || l)) ? w[11] : 1'b1;
    return {w[14] & !s, !w[14] & !s, w[13] & !f, jb, w[12], w[10] & !s};
  endfunction

  // Negotiation finished pulse; result line scrambled once released
  task automatic negotiate(input logic [3:0] r);
    @(posedge clk);
    an_done   <= 1'b1;
    an_result <= r;
    @(posedge clk);
    an_done   <= 1'b0;
    an_result <= ~r;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [15:0] w;
    logic [3:0]  res [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    strap_addr = 5'h13;
    strap_serial = 1'b1;
    {an_mode, an_done, speed_100, full_duplex, loopback_10, rx_pol_raw} = '0;
    an_result = '0;
    an_state_code = '0;
    cyc(3);
    rst <= 1'b0;
    // Reset values of both registers
    mgr.rd_reg(REG_VCS, d);
    chk_word(d, 16'hF130);
    mgr.rd_reg(REG_TBS, d);
    chk_word(d, 16'h7C00);
    $display("test reset_values done");
    // Read-only and reserved fields hold, address takes the write
    mgr.wr_rd_reg(REG_VCS, 16'hFFFF, d);
    chk_word(d, 16'hF1F0);
    chk_bits({1'b0, mgmt_device_address}, 6'h1F);
    mgr.wr_reg(REG_TBS, 16'hFFFF);
    mgr.rd_reg(REG_TBS, d);
    chk_word(d, 16'h7C00);
    mgr.wr_reg(REG_TBS, 16'h0000);
    mgr.rd_reg(REG_TBS, d);
    chk_word(d, 16'h0000);
    $display("test write_masks done");
    // Resolved mode from each negotiation outcome
    @(posedge clk) an_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      negotiate(res[i]);
      mgr.rd_reg(REG_VCS, d);
      chk_word({12'h0, d[15:12]}, {12'h0, res[i]});
    end
    chk_bits({5'h0, mode_flags_valid}, 6'h01);
    @(posedge clk) an_mode <= 1'b0;
    cyc(2);
    chk_bits({5'h0, mode_flags_valid}, 6'h00);
    $display("test negotiation done");
    // Every debug code, then an illegal one is dropped
    for (int c = 0; c < 10; c++) begin
      @(posedge clk) an_state_code <= 4'(c);
      mgr.rd_reg(REG_VCS, d);
      chk_word({12'h0, d[3:0]}, (c < 9) ? 16'(c) : 16'h0008);
    end
    $display("test debug_codes done");
    // Control outputs over config words and operating modes
    for (int k = 0; k < 16; k++) begin
      w = k[3] ? 16'h7C00 : 16'h0400;
      mgr.wr_reg(REG_TBS, w);
      @(posedge clk) {speed_100, full_duplex, loopback_10} <= k[2:0];
      cyc(3);
      chk_bits({link_pulse_tx, force_good_link, heartbeat_on, jabber_on, squelch_normal,
                serial_host_mode}, exp_ctl(w, k[2], k[1], k[0]));
    end
    $display("test controls done");
    // A one-cycle glitch is filtered; a steady reversal sets the flag
    @(posedge clk) rx_pol_raw <= 1'b1;
    @(posedge clk) rx_pol_raw <= 1'b0;
    mgr.rd_reg(REG_TBS, d);
    chk_word({15'h0, d[0]}, 16'h0000);
    @(posedge clk) rx_pol_raw <= 1'b1;
    cyc(5);
    mgr.wr_reg(REG_TBS, 16'h0000);
    mgr.rd_reg(REG_TBS, d);
    chk_word(d, 16'h0001);
    @(posedge clk) rx_pol_raw <= 1'b0;
    cyc(5);
    mgr.rd_reg(REG_TBS, d);
    chk_word(d, 16'h0000);
    $display("test polarity done");
    // Interrupt raise, mask, clear; write-only and unmapped reads
    mgr.wr_reg(REG_IRQ_CLR, 16'h0007);
    mgr.wr_reg(REG_IRQ_EN, 16'h0007);
    cyc(1);
    chk_bits({5'h0, irq}, 6'h00);
    negotiate(4'h4);
    // Event pulse lands on the same edge as the flags, status one edge later
    cyc(2);
    chk_bits({5'h0, irq}, 6'h01);
    mgr.wr_reg(REG_IRQ_EN, 16'h0000);
    cyc(1);
    chk_bits({5'h0, irq}, 6'h00);
    mgr.rd_reg(REG_IRQ_STAT, d);
    chk_word(d, 16'h0001);
    mgr.wr_reg(REG_IRQ_CLR, 16'h0001);
    mgr.rd_reg(REG_IRQ_STAT, d);
    chk_word(d, 16'h0000);
    mgr.rd_reg(REG_IRQ_CLR, d);
    chk_word(d, 16'h0000);
    mgr.wr_reg(5'h05, 16'hFFFF);
    mgr.rd_reg(5'h05, d);
    chk_word(d, 16'h0000);
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
